// file: cw_pkg.sv
`default_nettype none
package cw_pkg;
	// Register byte offsets
	localparam logic [7:0] CW_CTRL_OFS = 8'hc0;
	localparam logic [7:0] CW_ISTAT_OFS = 8'hc4;
	localparam logic [7:0] CW_IMASK_OFS = 8'hc8;
	localparam logic [7:0] CW_STATE_OFS = 8'hcc;
	// Control and interrupt register field positions
	localparam int CW_PRE_LSB = 4;
	localparam int CW_PRE_MSB = 7;
	localparam int CW_RSEL_BIT = 3;
	localparam int CW_WDS_BIT = 2;
	localparam int CW_RUN_BIT = 1;
	localparam int CW_UNLOCK_BIT = 0;
	localparam int CW_IRQ_TIMEOUT_BIT = 0;
	// Reset values of the control fields
	localparam logic [3:0] CW_PRE_RST = 4'h7;
	localparam logic CW_RSEL_RST = 1'b0;
	localparam logic CW_RUN_RST = 1'b1;
	// Lock bit inside the flash protection byte
	localparam logic [15:0] CW_FLASH_LOCK_ADDR = 16'h3ffa;
	localparam int CW_LOCK_BIT = 7;
	// Counter geometry, timing in crystal periods
	localparam int CW_CNT_W = 16;
	localparam logic [16:0] CW_BASE_PERIOD = 17'h00200;
	localparam logic [3:0] CW_PRE_MAX = 4'h7;
	localparam logic [3:0] CW_PRE_IMM = 4'h8;
	localparam logic [3:0] CW_PRE_IMM_DL = 4'h9;
	localparam int CW_XTAL_HZ = 32768;
	// Bus responses
	localparam logic [1:0] CW_RESP_OKAY = 2'h0;
	localparam logic [1:0] CW_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// file: cw_cnt_if.sv
`timescale 1ns/100ps
`default_nettype none
interface cw_cnt_if;
	logic tick;
	logic clear;
	logic run;
	logic [3:0] pre;
	logic timeout;
	logic [15:0] count;
	modport ctl (output tick, output clear, output run, output pre, input timeout, input count);
	modport cnt (input tick, input clear, input run, input pre, output timeout, output count);
endinterface // cw_cnt_if
`default_nettype wire

// file: cw_xtal_sync.sv
`timescale 1ns/100ps
`default_nettype none
module cw_xtal_sync (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic i_crystal_input,
	output logic o_rise
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic rise;
	} cw_sync_s;

	cw_sync_s st;
	cw_sync_s next_st;

	// Two-flop synchroniser, edge found behind the second flop
	always_comb begin
		next_st = st;
		if (i_ce) begin
			next_st.s1 = i_crystal_input;
			next_st.s2 = st.s1;
			next_st.s3 = st.s2;
			next_st.rise = st.s2 & ~st.s3; // [RULE4] [RULE18]
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_rise = st.rise;

	a_rise_single: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE4]
		(i_ce && st.rise) |=> !st.rise)
		else $error("crystal edge pulse lasted two cycles");
endmodule // cw_xtal_sync
`default_nettype wire

// file: cw_counter.sv
`timescale 1ns/100ps
`default_nettype none
module cw_counter (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	cw_cnt_if.cnt cnt
);
	typedef struct packed {
		logic [15:0] count;
		logic timeout;
	} cw_cnt_s;

	cw_cnt_s st;
	cw_cnt_s next_st;
	logic [15:0] last_count;

	// Last count before timeout: 2^(9+pre) crystal periods
	assign last_count = 16'((cw_pkg::CW_BASE_PERIOD << cnt.pre) - 17'h00001); // [RULE11]

	///////////////////////////////////////////////////////////////////////////
	// Counter and timeout decision
	always_comb begin
		next_st = st;
		if (i_ce) begin
			// One-cycle pulse at period end, high every cycle on codes 8 and 9 while running and not cleared; frozen with the rest while disabled
			next_st.timeout = 1'b0;
			if (cnt.clear || !cnt.run) begin
				next_st.count = 16'h0000; // [RULE2] [RULE16]
			end else if (cnt.pre == cw_pkg::CW_PRE_IMM || cnt.pre == cw_pkg::CW_PRE_IMM_DL) begin
				next_st.timeout = 1'b1; // [RULE13]
				next_st.count = 16'h0000;
			end else if (cnt.pre > cw_pkg::CW_PRE_MAX) begin
				next_st.count = st.count; // Invalid code, counter parked
			end else if (cnt.tick) begin
				if (st.count == last_count) begin
					next_st.timeout = 1'b1; // [RULE3] [RULE10] [RULE12]
					next_st.count = 16'h0000;
				end else begin
					next_st.count = st.count + 16'h0001; // [RULE4]
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign cnt.timeout = st.timeout;
	assign cnt.count = st.count;

	///////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	a_stop_quiet: assert property ((i_ce && !cnt.run) |=> !st.timeout) // [RULE2]
		else $error("timeout while stopped");
	a_period_exact: assert property ((i_ce && cnt.run && !cnt.clear && cnt.tick // [RULE11]
		&& cnt.pre <= cw_pkg::CW_PRE_MAX && st.count == last_count) |=> st.timeout)
		else $error("timeout missed at end of period");
	a_early_none: assert property ((i_ce && cnt.pre <= cw_pkg::CW_PRE_MAX // [RULE12]
		&& st.count != last_count && !(cnt.pre != $past(cnt.pre)))
		|=> !st.timeout || $past(cnt.pre) != cnt.pre)
		else $error("timeout before end of period");
	a_imm_reset: assert property ((i_ce && cnt.run && !cnt.clear // [RULE13]
		&& cnt.pre == cw_pkg::CW_PRE_IMM) |=> st.timeout)
		else $error("immediate code did not time out");
	a_clear_zero: assert property ((i_ce && cnt.clear) |=> st.count == 16'h0000) // [RULE16]
		else $error("re-arm did not clear counter");
endmodule // cw_counter
`default_nettype wire

// file: cw_watchdog.sv
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// [RULE1] After reset the watchdog runs with a two-second timeout and resets.
// [RULE2] Clearing the run bit stops the watchdog; no timeout is raised.
// [RULE3] Missing re-arm within the prescale period raises reset or interrupt and flags it.
// [RULE4] Counter advances on crystal edges, independent of the core clock rate.
// [RULE5] Control writes apply only right after an unlock write.
// [RULE6] A flash-held lock bit freezes run and response settings.
// [RULE7] Lock comes from flash byte 0x3FFA bit 7, active when zero.
// [RULE8] While locked, response select reads 0 and run reads 1.
// [RULE9] Prescale sits in control bits 7..4, reset value 7.
// [RULE10] Sixteen-bit counter; prescale picks the upper bit that times out.
// [RULE11] Timeout period is 2^prescale times 512 crystal periods.
// [RULE12] Codes 0..7 give 15.6 ms up to 2 s.
// [RULE13] Code 8 gives an immediate system reset; the code times out at once and gives an interrupt instead when bit 3 is set.
// [RULE14] Bit 3 selects reset when clear, interrupt when set.
// [RULE15] Bit 2 flags every timeout; cleared by writing zero or pin reset.
// [RULE16] Writing one to run bit 1 enables and restarts the counter.
// [RULE17] Software sets unlock bit 0, then writes control next.
// [RULE18] Control fields reach the crystal-paced counter safely; timeout returns likewise.
module cw_watchdog (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic i_crystal_input,
	input wire logic [7:0] i_flash_prot_byte,
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [7:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic o_sys_rst,
	output logic o_irq
);
	typedef struct packed {
		logic awready;
		logic wready;
		logic arready;
		logic aw_full;
		logic [7:0] aw_addr;
		logic w_full;
		logic [7:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [3:0] pre;
		logic rsel;
		logic timeout_status;
		logic run;
		logic unlock;
		logic lock;
		logic lock_taken;
		logic irq_stat;
		logic irq_mask;
		logic irq;
		logic sys_rst;
	} cw_top_s;

	localparam cw_top_s CW_TOP_RST = '{
		awready: 1'b1,
		wready: 1'b1,
		arready: 1'b1,
		aw_full: 1'b0,
		aw_addr: 8'h00,
		w_full: 1'b0,
		w_data: 8'h00,
		w_lane0: 1'b0,
		bvalid: 1'b0,
		bresp: cw_pkg::CW_RESP_OKAY,
		rvalid: 1'b0,
		rdata: 32'h0000_0000,
		rresp: cw_pkg::CW_RESP_OKAY,
		pre: cw_pkg::CW_PRE_RST,
		rsel: cw_pkg::CW_RSEL_RST,
		timeout_status: 1'b0,
		run: cw_pkg::CW_RUN_RST,
		unlock: 1'b0,
		lock: 1'b0,
		lock_taken: 1'b0,
		irq_stat: 1'b0,
		irq_mask: 1'b0,
		irq: 1'b0,
		sys_rst: 1'b0
	};

	cw_top_s st;
	cw_top_s next_st;
	logic wr_fire;
	logic wr_ctrl_apply;
	logic clr_cnt;
	logic xtal_rise;
	logic [7:0] ctrl_view;
	logic [31:0] rd_val;
	logic rd_hit;

	cw_cnt_if cnt_bus ();

	///////////////////////////////////////////////////////////////////////////
	// Crystal edge detection and counter
	cw_xtal_sync u_sync (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_ce(i_ce),
		.i_crystal_input(i_crystal_input),
		.o_rise(xtal_rise)
	);

	cw_counter u_counter (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_ce(i_ce),
		.cnt(cnt_bus.cnt)
	);

	// Registered control fields steer the counter
	assign cnt_bus.tick = xtal_rise; // [RULE4]
	assign cnt_bus.run = st.run; // [RULE18]
	assign cnt_bus.pre = st.pre; // [RULE18]
	assign cnt_bus.clear = clr_cnt;

	// Control register image as software sees it
	assign ctrl_view = {st.pre, st.rsel, st.timeout_status, st.run, st.unlock};

	///////////////////////////////////////////////////////////////////////////
	// Read decode
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (i_s_axi_araddr)
			cw_pkg::CW_CTRL_OFS: begin
				rd_val = {24'h000000, ctrl_view};
			end
			cw_pkg::CW_ISTAT_OFS: begin
				rd_val = {31'h0000_0000, st.irq_stat};
			end
			cw_pkg::CW_IMASK_OFS: begin
				rd_val = {31'h0000_0000, st.irq_mask};
			end
			cw_pkg::CW_STATE_OFS: begin
				rd_val = {cnt_bus.count, 15'h0000, st.lock};
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	///////////////////////////////////////////////////////////////////////////
	// Next state: bus slave, control register, events
	always_comb begin
		next_st = st;
		wr_fire = 1'b0;
		wr_ctrl_apply = 1'b0;
		clr_cnt = 1'b0;
		if (i_ce) begin
			next_st.sys_rst = 1'b0;
			// Lock strap taken once, after reset release
			if (!st.lock_taken) begin
				next_st.lock_taken = 1'b1;
				next_st.lock = ~i_flash_prot_byte[cw_pkg::CW_LOCK_BIT]; // [RULE6] [RULE7]
			end
			// Address and data channels, taken in either order
			if (i_s_axi_awvalid && st.awready) begin
				next_st.aw_full = 1'b1;
				next_st.aw_addr = i_s_axi_awaddr;
			end
			if (i_s_axi_wvalid && st.wready) begin
				next_st.w_full = 1'b1;
				next_st.w_data = i_s_axi_wdata[7:0];
				next_st.w_lane0 = i_s_axi_wstrb[0];
			end
			if (st.bvalid && i_s_axi_bready) begin
				next_st.bvalid = 1'b0;
			end
			// Write executes once both halves are held
			if (st.aw_full && st.w_full && !st.bvalid) begin
				wr_fire = 1'b1;
				next_st.aw_full = 1'b0;
				next_st.w_full = 1'b0;
				next_st.bvalid = 1'b1;
				next_st.bresp = cw_pkg::CW_RESP_OKAY;
				// Every write drops the unlock, the awaited control write included
				next_st.unlock = 1'b0; // [RULE5] [RULE17]
				unique case (st.aw_addr)
					cw_pkg::CW_CTRL_OFS: begin
						if (st.w_lane0 && st.unlock) begin
							wr_ctrl_apply = 1'b1; // [RULE5]
							next_st.pre = st.w_data[cw_pkg::CW_PRE_MSB:cw_pkg::CW_PRE_LSB]; // [RULE9]
							next_st.rsel = st.w_data[cw_pkg::CW_RSEL_BIT]; // [RULE14]
							next_st.run = st.w_data[cw_pkg::CW_RUN_BIT]; // [RULE2]
							if (!st.w_data[cw_pkg::CW_WDS_BIT]) begin
								next_st.timeout_status = 1'b0; // [RULE15]
							end
							clr_cnt = st.w_data[cw_pkg::CW_RUN_BIT]; // [RULE16]
						end else if (st.w_lane0 && st.w_data[cw_pkg::CW_UNLOCK_BIT]) begin
							next_st.unlock = 1'b1; // [RULE5] [RULE17]
						end
					end
					cw_pkg::CW_ISTAT_OFS: begin
						if (st.w_lane0 && st.w_data[cw_pkg::CW_IRQ_TIMEOUT_BIT]) begin
							next_st.irq_stat = 1'b0;
						end
					end
					cw_pkg::CW_IMASK_OFS: begin
						if (st.w_lane0) begin
							next_st.irq_mask = st.w_data[cw_pkg::CW_IRQ_TIMEOUT_BIT];
						end
					end
					cw_pkg::CW_STATE_OFS: begin
						next_st.bresp = cw_pkg::CW_RESP_SLVERR;
					end
					default: begin
						next_st.bresp = cw_pkg::CW_RESP_SLVERR;
					end
				endcase
			end
			// Read channel answers one cycle after the address
			if (st.rvalid && i_s_axi_rready) begin
				next_st.rvalid = 1'b0;
				next_st.arready = 1'b1;
			end
			if (i_s_axi_arvalid && st.arready) begin
				next_st.arready = 1'b0;
				next_st.rvalid = 1'b1;
				next_st.rdata = rd_val;
				next_st.rresp = rd_hit ? cw_pkg::CW_RESP_OKAY : cw_pkg::CW_RESP_SLVERR;
			end
			// Timeout event; setting wins over a same-cycle clear
			if (cnt_bus.timeout) begin
				next_st.timeout_status = 1'b1; // [RULE3] [RULE15]
				if (st.rsel) begin
					next_st.irq_stat = 1'b1; // [RULE14]
				end else begin
					next_st.sys_rst = 1'b1; // [RULE1] [RULE14]
				end
			end
			// Lock overrides response and run settings
			if (next_st.lock) begin
				next_st.rsel = 1'b0; // [RULE8]
				next_st.run = 1'b1; // [RULE8]
			end
			next_st.awready = !next_st.aw_full && !next_st.bvalid;
			next_st.wready = !next_st.w_full && !next_st.bvalid;
			next_st.irq = next_st.irq_stat && next_st.irq_mask;
		end
	end

	// Synchronous pin reset restores every field, timeout flag included
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			st <= CW_TOP_RST; // [RULE1] [RULE9] [RULE15]
		end else begin
			st <= next_st;
		end
	end

	///////////////////////////////////////////////////////////////////////////
	// Outputs straight from flops
	assign o_s_axi_awready = st.awready;
	assign o_s_axi_wready = st.wready;
	assign o_s_axi_bresp = st.bresp;
	assign o_s_axi_bvalid = st.bvalid;
	assign o_s_axi_arready = st.arready;
	assign o_s_axi_rdata = st.rdata;
	assign o_s_axi_rresp = st.rresp;
	assign o_s_axi_rvalid = st.rvalid;
	assign o_sys_rst = st.sys_rst;
	assign o_irq = st.irq;

	///////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	sequence s_unlock_arm;
		wr_fire && st.aw_addr == cw_pkg::CW_CTRL_OFS && !st.unlock && st.w_lane0
			&& st.w_data[cw_pkg::CW_UNLOCK_BIT];
	endsequence

	sequence s_ctrl_commit;
		wr_fire && st.aw_addr == cw_pkg::CW_CTRL_OFS && st.unlock && st.w_lane0;
	endsequence

	a_reset_default: assert property ($past(!i_rst_b) |-> st.pre == cw_pkg::CW_PRE_RST // [RULE1]
		&& st.run && !st.rsel && !st.timeout_status)
		else $error("control fields wrong after reset");
	a_blind_write: assert property ((wr_fire && !st.unlock) |=> st.pre == $past(st.pre)) // [RULE5]
		else $error("prescale changed without unlock");
	a_unlock_commit: assert property ((s_unlock_arm ##1 !wr_fire[*2] ##1 s_ctrl_commit) // [RULE17]
		|=> st.pre == $past(st.w_data[cw_pkg::CW_PRE_MSB:cw_pkg::CW_PRE_LSB]))
		else $error("unlocked write not applied");
	a_lock_force: assert property ((st.lock && st.lock_taken) |-> !st.rsel && st.run) // [RULE8]
		else $error("lock did not hold run and response");
	a_timeout_flag: assert property ((i_ce && cnt_bus.timeout) |=> st.timeout_status) // [RULE15]
		else $error("timeout flag not set");
	a_timeout_reset: assert property ((i_ce && cnt_bus.timeout && !st.rsel) |=> o_sys_rst) // [RULE14]
		else $error("reset response missing");
	a_timeout_irq: assert property ((i_ce && cnt_bus.timeout && st.rsel) // [RULE3]
		|=> st.irq_stat && !o_sys_rst)
		else $error("interrupt response missing");
	a_rearm_clear: assert property ((s_ctrl_commit ##0 st.w_data[cw_pkg::CW_RUN_BIT]) // [RULE16]
		|=> cnt_bus.count == 16'h0000)
		else $error("re-arm did not restart counter");
	a_reset_cause: assert property (o_sys_rst |-> $past(cnt_bus.timeout)) // [RULE3]
		else $error("system reset without timeout");

	// Bus answers stand until the master takes them
	a_bresp_hold: assert property ((o_s_axi_bvalid && !i_s_axi_bready) // [RULE5]
		|=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
		else $error("write response dropped before it was taken");
	a_rdata_hold: assert property ((o_s_axi_rvalid && !i_s_axi_rready) // [RULE5]
		|=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
		else $error("read data dropped before it was taken");

	// An unlock serves one control write only
	a_unlock_spent: assert property (s_ctrl_commit |=> !st.unlock) // [RULE5]
		else $error("unlock survived a control write");

	// Timeout flag stays until a write or a pin reset clears it
	a_wds_sticky: assert property ((st.timeout_status && !wr_fire) |=> st.timeout_status) // [RULE15]
		else $error("timeout flag lost without a clear");

	// Unmasked interrupt-mode timeout raises the interrupt line
	a_irq_raise: assert property ((i_ce && cnt_bus.timeout && st.rsel // [RULE14]
		&& st.irq_mask && !wr_fire) |=> o_irq)
		else $error("interrupt line not raised");
endmodule // cw_watchdog
`default_nettype wire

// file: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [31:0] wd;
		logic [1:0] resp;
		logic [31:0] rd;
	} cw_row_s;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic xtal = 1'b0;
	logic xen = 1'b0;
	logic ce = 1'b1;
	logic [1:0] xdiv = 2'h0;
	logic [7:0] flash = 8'hff;
	logic [7:0] awaddr = 8'h0;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic wvalid = 1'b0;
	logic bready = 1'b1; // Response ready held high throughout
	logic [7:0] araddr = 8'h0;
	logic arvalid = 1'b0;
	logic rready = 1'b1; // Response ready held high throughout
	logic awready, wready, bvalid, arready, rvalid, sys_rst, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	cw_row_s rows [0:8];
	int fail_count = 0;
	int tests_run = 0;

	////////////////////////////////////////////////////////////////
	// Clock and a fast crystal stand-in, one tick every four cycles
	always #20 clk = ~clk;
	always @(posedge clk) begin
		if (xen) begin
			xdiv <= xdiv + 2'h1;
			if (xdiv[0])
				xtal <= ~xtal;
		end
	end

	cw_watchdog cw_watchdog_inst (.i_clk(clk), .i_rst_b(rst_b), .i_ce(ce),
		.i_crystal_input(xtal), .i_flash_prot_byte(flash),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
		.i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
		.i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
		.o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_sys_rst(sys_rst), .o_irq(irq));

	////////////////////////////////////////////////////////////////
	// Verdict and comparisons
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic miss(input string m);
		fail_count++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
			miss($sformatf("data %h expected %h", g, e));
	endtask
	task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
		tests_run++;
		if (g !== e)
			miss($sformatf("response %h expected %h", g, e));
	endtask
	task automatic chk_bit(input logic g, input logic e);
		tests_run++;
		if (g !== e)
			miss($sformatf("flag %b expected %b", g, e));
	endtask
	task automatic chk_range(input int g, input int lo, input int hi);
		tests_run++;
		if (g < lo || g > hi)
			miss($sformatf("delay %0d outside %0d..%0d", g, lo, hi));
	endtask

	////////////////////////////////////////////////////////////////
	// Bus cycles, entered and left just after a rising edge
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		r = 2'h3;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'h1;
		wvalid <= 1'b1;
		while (n < 50) begin
			@(posedge clk);
			n++;
			if (awvalid && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				n = 99;
			end
		end
		if (n != 99) begin
			miss("write hang");
			close_out();
		end
	endtask
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		r = 2'h3;
		d = 32'h0;
		araddr <= a;
		arvalid <= 1'b1;
		while (n < 50) begin
			@(posedge clk);
			n++;
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				n = 99;
			end
		end
		if (n != 99) begin
			miss("read hang");
			close_out();
		end
	endtask
	// Unlock then write control, the only way it changes
	task automatic ctrl_wr(input logic [31:0] d);
		logic [1:0] r;
		axi_write(8'hc0, 32'h1, r);
		axi_write(8'hc0, d, r);
		chk_resp(r, 2'h0);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axi_read(a, d, r);
		chk_resp(r, 2'h0);
		chk_data(d, e);
	endtask
	// Wait for one response, the other one must stay quiet
	task automatic wait_evt(input bit use_irq, input int lim, output int n);
		n = 0;
		while (n < lim) begin
			@(posedge clk);
			n++;
			if ((use_irq ? sys_rst : irq) === 1'b1)
				miss("wrong timeout response");
			if ((use_irq ? irq : sys_rst) === 1'b1)
				return;
		end
		miss("timeout event missing");
		close_out();
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int n;
		logic hit;
		rows = '{'{1'b0, 8'hc0, 32'h0, 2'h0, 32'h72}, '{1'b1, 8'hc0, 32'h0, 2'h0, 32'h0},
			'{1'b0, 8'hc0, 32'h0, 2'h0, 32'h72}, '{1'b1, 8'hc8, 32'h1, 2'h0, 32'h0},
			'{1'b0, 8'hc8, 32'h0, 2'h0, 32'h1}, '{1'b0, 8'hd0, 32'h0, 2'h2, 32'h0},
			'{1'b1, 8'hd0, 32'h1, 2'h2, 32'h0}, '{1'b1, 8'hcc, 32'h1, 2'h2, 32'h0},
			'{1'b0, 8'hc4, 32'h0, 2'h0, 32'h0}};
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				axi_write(rows[i].addr, rows[i].wd, r);
				chk_resp(r, rows[i].resp);
			end else begin
				axi_read(rows[i].addr, d, r);
				chk_resp(r, rows[i].resp);
				chk_data(d, rows[i].rd);
			end
		end
		// Interrupt response, prescale 0
		xen <= 1'b1;
		ctrl_wr(32'h0a);
		wait_evt(1'b1, 4000, n);
		chk_range(n, 2030, 2070);
		rd_chk(8'hc0, 32'h0e);
		rd_chk(8'hc4, 32'h1);
		axi_write(8'hc8, 32'h0, r);
		repeat (2) @(posedge clk);
		chk_bit(irq, 1'b0);
		axi_write(8'hc8, 32'h1, r);
		repeat (2) @(posedge clk);
		chk_bit(irq, 1'b1);
		axi_write(8'hc4, 32'h1, r);
		repeat (2) @(posedge clk);
		chk_bit(irq, 1'b0);
		// Reset response, prescale 0 and 1
		for (int p = 0; p < 2; p++) begin
			ctrl_wr({24'h0, p[3:0], 4'h2});
			wait_evt(1'b0, 9000, n);
			chk_range(n, (2048 << p) - 18, (2048 << p) + 22);
		end
		rd_chk(8'hc0, 32'h16);
		// Stopped, then parked on an unused code: both stay quiet
		for (int q = 0; q < 2; q++) begin
			ctrl_wr(q ? 32'ha2 : 32'h00);
			rd_chk(8'hc0, q ? 32'ha2 : 32'h00);
			hit = 1'b0;
			repeat (3000) begin
				@(posedge clk);
				hit = hit | (sys_rst !== 1'b0) | (irq !== 1'b0);
			end
			chk_bit(hit, 1'b0);
		end
		// Clock enable low freezes the count, then the period completes
		ctrl_wr(32'h02);
		ce <= 1'b0;
		hit = 1'b0;
		repeat (3000) begin
			@(posedge clk);
			hit = hit | (sys_rst !== 1'b0);
		end
		ce <= 1'b1;
		chk_bit(hit, 1'b0);
		wait_evt(1'b0, 4000, n);
		chk_range(n, 2030, 2070);
		// Codes 8 and 9 reset at once
		for (int p = 8; p < 10; p++) begin
			ctrl_wr({24'h0, p[3:0], 4'h2});
			wait_evt(1'b0, 20, n);
			chk_range(n, 1, 20);
			ctrl_wr(32'h00);
		end
		// Locked strap from the flash byte, pin reset while stopped
		xen <= 1'b0;
		flash <= 8'h7f;
		rst_b <= 1'b0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		axi_read(8'hcc, d, r);
		chk_bit(d[0], 1'b1);
		ctrl_wr(32'h08);
		rd_chk(8'hc0, 32'h02);
		xen <= 1'b1;
		wait_evt(1'b0, 4000, n);
		chk_range(n, 2030, 2070);
		close_out();
	end
endmodule // tb
`default_nettype wire
